/* design/gcps_top.sv */
// Global clock line selection and PLL configuration with a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module gcps_top
  import gcps_pkg::*;
#(
  parameter int NUM_PLL = 2,
  parameter int NUM_LINES = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic [3:0] ded_clk_pins_i,
  input wire logic [7:0] dual_purpose_clock_pins_i,
  input wire logic [7:0] logic_array_clk_i,
  output logic [7:0] global_line_o,
  output logic [1:0] pll_one_external_output_o,
  output logic [1:0] pll_one_external_output_oe_n_o,
  output logic [1:0] pll_two_external_output_o,
  output logic [1:0] pll_two_external_output_oe_n_o,
  input wire logic [1:0] pll_one_user_io_i,
  input wire logic [1:0] pll_one_user_io_oe_n_i,
  input wire logic [1:0] pll_two_user_io_i,
  input wire logic [1:0] pll_two_user_io_oe_n_i
);
  `include "gcps_consts.svh"

  // Merge a write with byte enables over the current register value
  function automatic logic [31:0] wb_merge(input logic [31:0] cur,
                                           input logic [31:0] wd,
                                           input logic [3:0] sel);
    logic [31:0] mask;
    mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    wb_merge = (cur & ~mask) | (wd & mask);
  endfunction : wb_merge

  // Divider range check, shared by m, n and post-scale fields
  function automatic logic in_range(input logic [5:0] v,
                                    input logic [5:0] lo);
    in_range = (v >= lo) && (v <= `GCPS_NC_MAX);
  endfunction : in_range

  // Synchronisers for pin inputs; stage one is read by stage two only
  // A pin edge near the clock edge costs a cycle of delay, never a glitch
  logic [3:0] ded_s1_q;
  logic [3:0] ded_s2_q;
  logic [7:0] dual_s1_q;
  logic [7:0] dual_s2_q;
  always_ff @(posedge clk_i) begin
    ded_s1_q <= ded_clk_pins_i;
    ded_s2_q <= ded_s1_q;
    dual_s1_q <= dual_purpose_clock_pins_i;
    dual_s2_q <= dual_s1_q;
  end

  // Configuration registers
  // An absent second PLL keeps its reset values and reads as zero
  gcps_div_t m_q [2];
  gcps_div_t n_q [2];
  gcps_div_t post_q [2][2];
  gcps_step_t phase_q [2][2];
  gcps_step_t duty_q [2][2];
  logic [1:0] lvds_q;
  logic [1:0] ext_en_q;
  logic [1:0] ext_diff_q;
  logic [23:0] line_sel_q;
  logic run_q;
  logic [1:0] alive;
  logic [1:0] cnt_out [2];

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
  // Word 3 of each PLL window is a hole and reads as zero
  wire in_pll = (adr < `GCPS_OFS_LINESEL) && (adr[3:0] != 4'hc);
  wire pll_idx = adr[4];
  wire [7:0] pll_ofs = {4'h0, adr[3:0]};
  wire pll_ok = in_pll && (int'(pll_idx) < NUM_PLL);
  wire cfg_open = ~run_q;

  // Register image words; every field arrives as an argument, since a
  // continuous assignment only wakes up when its operands change
  function automatic logic [31:0] div_word(input gcps_div_t m,
                                           input gcps_div_t n,
                                           input logic lvds,
                                           input logic ext_en,
                                           input logic ext_diff);
    div_word = 32'h0;
    div_word[`GCPS_DIV_M_LSB +: 6] = m;
    div_word[`GCPS_DIV_N_LSB +: 6] = n;
    div_word[`GCPS_DIV_LVDS_BIT] = lvds;
    div_word[`GCPS_DIV_EXTEN_BIT] = ext_en;
    div_word[`GCPS_DIV_EXTDIFF_BIT] = ext_diff;
  endfunction : div_word

  function automatic logic [31:0] cnt_word(input gcps_div_t post,
                                           input gcps_step_t phase,
                                           input gcps_step_t duty);
    cnt_word = 32'h0;
    cnt_word[`GCPS_CNT_POST_LSB +: 6] = post;
    cnt_word[`GCPS_CNT_PHASE_LSB +: 8] = phase;
    cnt_word[`GCPS_CNT_DUTY_LSB +: 8] = duty;
  endfunction : cnt_word

  wire [31:0] status_word = {19'h0, run_q,
                             2'(NUM_PLL == 2 ? 2'b11 : 2'b01),
                             alive, global_line_o};
  // Fields of the addressed PLL
  wire [31:0] div_img = div_word(m_q[pll_idx], n_q[pll_idx], lvds_q[pll_idx],
                                 ext_en_q[pll_idx], ext_diff_q[pll_idx]);
  wire [31:0] cnt0_img = cnt_word(post_q[pll_idx][0], phase_q[pll_idx][0],
                                  duty_q[pll_idx][0]);
  wire [31:0] cnt1_img = cnt_word(post_q[pll_idx][1], phase_q[pll_idx][1],
                                  duty_q[pll_idx][1]);
  wire [31:0] pll_word = (pll_ofs == `GCPS_OFS_DIV) ? div_img :
                         (pll_ofs == `GCPS_OFS_CNT0) ? cnt0_img : cnt1_img;
  // Unmapped offsets and an absent PLL read as zero
  wire [31:0] rd_word = pll_ok ? pll_word :
                        (adr == `GCPS_OFS_LINESEL) ? {8'h0, line_sel_q} :
                        (adr == `GCPS_OFS_CTRL) ? {31'h0, run_q} :
                        (adr == `GCPS_OFS_STATUS) ? status_word : 32'h0;
  wire [31:0] wd = wb_merge(rd_word, wb_dat_i, wb_sel_i);

  // Proposed field values; out of range values leave the field unchanged
  wire [5:0] wd_m = wd[`GCPS_DIV_M_LSB +: 6];
  wire [5:0] wd_n = wd[`GCPS_DIV_N_LSB +: 6];
  wire [5:0] wd_post = wd[`GCPS_CNT_POST_LSB +: 6];
  wire [7:0] wd_phase = wd[`GCPS_CNT_PHASE_LSB +: 8];
  wire [7:0] wd_duty = wd[`GCPS_CNT_DUTY_LSB +: 8];
  wire m_ok = in_range(wd_m, `GCPS_M_MIN);
  wire n_ok = in_range(wd_n, `GCPS_NC_MIN);
  wire post_ok = in_range(wd_post, `GCPS_NC_MIN);
  wire cnt_sel = (pll_ofs == `GCPS_OFS_CNT1);
  wire cnt_wr = wr && cfg_open && pll_ok && (pll_ofs != `GCPS_OFS_DIV);
  wire div_wr = wr && cfg_open && pll_ok && (pll_ofs == `GCPS_OFS_DIV);

  // Bus answer: one cycle after the request, one cycle long
  // No wait states, so the master never sees a stretched cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? rd_word : 32'h0;
    end
  end

  // Global register strobes; all writes are dropped once running
  wire sel_wr = wr && cfg_open && (adr == `GCPS_OFS_LINESEL);
  wire ctrl_wr = wr && cfg_open && (adr == `GCPS_OFS_CTRL);

  // Global settings; run can only be set, so the setup stays frozen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_sel_q <= 24'h0;
      run_q <= 1'b0;
    end else begin
      if (sel_wr) line_sel_q <= wd[23:0];
      if (ctrl_wr) run_q <= wd[0];
    end
  end

  // Per-PLL settings, only while stopped
  // A divider outside its range keeps the old value; the rest lands
  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_cfg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          m_q[k] <= `GCPS_RST_M;
          n_q[k] <= `GCPS_RST_N;
          lvds_q[k] <= 1'b0;
          ext_en_q[k] <= 1'b0;
          ext_diff_q[k] <= 1'b0;
        end else if (div_wr && (int'(pll_idx) == k)) begin
          if (m_ok) m_q[k] <= wd_m;
          if (n_ok) n_q[k] <= wd_n;
          lvds_q[k] <= wd[`GCPS_DIV_LVDS_BIT];
          ext_en_q[k] <= wd[`GCPS_DIV_EXTEN_BIT];
          ext_diff_q[k] <= wd[`GCPS_DIV_EXTDIFF_BIT];
        end
      end
      for (genvar c = 0; c < 2; c++) begin : g_c
        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            post_q[k][c] <= `GCPS_RST_POST;
            phase_q[k][c] <= `GCPS_RST_PHASE;
            duty_q[k][c] <= `GCPS_RST_DUTY;
          end else if (cnt_wr && (int'(pll_idx) == k) && (int'(cnt_sel) == c)) begin
            if (post_ok) post_q[k][c] <= wd_post;
            phase_q[k][c] <= wd_phase;
            duty_q[k][c] <= wd_duty;
          end
        end
      end
    end
  endgenerate

  // PLL instances; the smaller variant leaves the second slot empty
  // The reference is sampled, so it must stay well below half the clock
  generate
    for (k = 0; k < 2; k++) begin : g_pll
      if (k < NUM_PLL) begin : g_on
        gcps_pll_if pif ();
        // Reference from pin 2k, or the pair 2k/2k+1 as LVDS
        assign pif.ref_clk = lvds_q[k] ?
          (ded_s2_q[2*k] & ~ded_s2_q[2*k+1]) : ded_s2_q[2*k];
        assign pif.run = run_q;
        assign pif.m = m_q[k];
        assign pif.n = n_q[k];
        assign pif.post = post_q[k];
        assign pif.phase = phase_q[k];
        assign pif.duty = duty_q[k];
        assign cnt_out[k] = pif.cnt_out;
        assign alive[k] = pif.alive;
        gcps_pll u_pll (
          .clk_i (clk_i),
          .rst_i (rst_i),
          .pif (pif)
        );
      end else begin : g_off
        assign cnt_out[k] = 2'b00;
        assign alive[k] = 1'b0;
      end
    end
  endgenerate

  // Line source mux; PLL counter and pin choice are fixed per line
  // Codes with no source for a line leave it low
  logic [7:0] line_d;
  generate
    for (k = 0; k < NUM_LINES; k++) begin : g_line
      localparam int PLL = k / 4;
      localparam int CNT = ((k % 4) == 1 || (k % 4) == 2) ? 0 : 1;
      localparam int PIN = (k / 4) * 2 + (k % 2);
      wire [2:0] sel = line_sel_q[k*`GCPS_SEL_W +: `GCPS_SEL_W];
      assign line_d[k] =
        (sel == GCPS_SRC_PLL) ? cnt_out[PLL][CNT] :
        (sel == GCPS_SRC_PIN) ? ded_s2_q[PIN] :
        (sel == GCPS_SRC_DUAL) ? dual_s2_q[k] :
        (sel == GCPS_SRC_LOGIC) ? logic_array_clk_i[k] : 1'b0;
    end
  endgenerate

  // External outputs: counter 0 drives p, n carries its inverse in
  // differential mode; otherwise the pins act as user I/O
  // While counter 0 drives the pins, the negative leg is only enabled in differential mode; as user I/O, uio_oe_n decides
  logic [1:0] ext_d [2];
  logic [1:0] ext_oe_n_d [2];
  wire [1:0] uio [2] = '{pll_one_user_io_i, pll_two_user_io_i};
  wire [1:0] uio_oe_n [2] = '{pll_one_user_io_oe_n_i, pll_two_user_io_oe_n_i};
  generate
    for (k = 0; k < 2; k++) begin : g_ext
      wire on = ext_en_q[k] && run_q && (k < NUM_PLL);
      assign ext_d[k] = on ? {~cnt_out[k][0], cnt_out[k][0]} : uio[k];
      assign ext_oe_n_d[k] = !on ? uio_oe_n[k] :
                             {~ext_diff_q[k], 1'b0};
    end
  endgenerate

  // Output flops
  // Reset leaves every external pin released
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_line_o <= 8'h00;
      pll_one_external_output_o <= 2'b00;
      pll_two_external_output_o <= 2'b00;
      pll_one_external_output_oe_n_o <= 2'b11;
      pll_two_external_output_oe_n_o <= 2'b11;
    end else begin
      global_line_o <= line_d;
      pll_one_external_output_o <= ext_d[0];
      pll_two_external_output_o <= ext_d[1];
      pll_one_external_output_oe_n_o <= ext_oe_n_d[0];
      pll_two_external_output_oe_n_o <= ext_oe_n_d[1];
    end
  end
endmodule : gcps_top
`default_nettype wire

/* design/gcps_consts.svh */
// Register offsets, field positions and reset values of the clock select block
`ifndef GCPS_CONSTS_SVH
`define GCPS_CONSTS_SVH

// Register byte offsets; each PLL owns a 16-byte window at PLL_STRIDE
`define GCPS_OFS_DIV 8'h00
`define GCPS_OFS_CNT0 8'h04
`define GCPS_OFS_CNT1 8'h08
`define GCPS_PLL_STRIDE 8'h10
`define GCPS_OFS_LINESEL 8'h20
`define GCPS_OFS_CTRL 8'h24
`define GCPS_OFS_STATUS 8'h28

// Divider register fields
`define GCPS_DIV_M_LSB 0
`define GCPS_DIV_N_LSB 8
`define GCPS_DIV_LVDS_BIT 16
`define GCPS_DIV_EXTEN_BIT 17
`define GCPS_DIV_EXTDIFF_BIT 18

// Counter register fields
`define GCPS_CNT_POST_LSB 0
`define GCPS_CNT_PHASE_LSB 8
`define GCPS_CNT_DUTY_LSB 16

// Line select: three bits per global line
`define GCPS_SEL_W 3

// Status register fields
`define GCPS_ST_LINES_LSB 0
`define GCPS_ST_ALIVE_LSB 8
`define GCPS_ST_PRESENT_LSB 10
`define GCPS_ST_RUN_BIT 12

// Divider limits
`define GCPS_M_MIN 6'h02
`define GCPS_M_MAX 6'h20
`define GCPS_NC_MIN 6'h01
`define GCPS_NC_MAX 6'h20

// Reset values
`define GCPS_RST_M 6'h02
`define GCPS_RST_N 6'h01
`define GCPS_RST_POST 6'h01
`define GCPS_RST_PHASE 8'h00
`define GCPS_RST_DUTY 8'h04

// Oscillator steps per oscillator period (phase resolution)
`define GCPS_STEPS 8

`endif

/* design/gcps_pkg.sv */
// Types shared by the clock select block
package gcps_pkg;

  // Source of one global clock line
  typedef enum logic [2:0] {
    GCPS_SRC_OFF = 3'h0,
    GCPS_SRC_PLL = 3'h1,
    GCPS_SRC_PIN = 3'h2,
    GCPS_SRC_DUAL = 3'h3,
    GCPS_SRC_LOGIC = 3'h4
  } gcps_src_t;

  typedef logic [5:0] gcps_div_t;
  typedef logic [7:0] gcps_step_t;

endpackage : gcps_pkg

/* design/gcps_pll_if.sv */
// Configuration and output bundle between the top and one PLL model
`timescale 1ns/1ps
`default_nettype none
interface gcps_pll_if;
  import gcps_pkg::*;
  logic run;
  logic ref_clk;
  gcps_div_t m;
  gcps_div_t n;
  gcps_div_t post [2];
  gcps_step_t phase [2];
  gcps_step_t duty [2];
  logic [1:0] cnt_out;
  logic alive;

  modport cfg (output run, ref_clk, m, n, post, phase, duty,
               input cnt_out, alive);
  modport pll (input run, ref_clk, m, n, post, phase, duty,
               output cnt_out, alive);
endinterface : gcps_pll_if
`default_nettype wire

/* design/gcps_pll.sv */
// Digital model of one PLL: m/n rate synthesis and two post-scale counters
`timescale 1ns/1ps
`default_nettype none
module gcps_pll
  import gcps_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  gcps_pll_if.pll pif
);
  `include "gcps_consts.svh"

  logic ref_q;
  logic [5:0] ndiv_q;
  logic [9:0] credit_q;
  logic alive_q;
  logic [1:0] out_q;
  wire ref_rise = pif.ref_clk & ~ref_q;
  // Every n reference edges the oscillator earns 8*m steps
  wire ndiv_wrap = ref_rise && ((ndiv_q + 6'h01) >= pif.n);
  wire tick = (credit_q != 10'h000);
  wire [9:0] feed = ndiv_wrap ? {1'b0, pif.m, 3'h0} : 10'h000;

  // Input divider and oscillator step credit; halted until run
  always_ff @(posedge clk_i) begin
    if (rst_i || !pif.run) begin
      ref_q <= 1'b0;
      ndiv_q <= 6'h00;
      credit_q <= 10'h000;
      alive_q <= 1'b0;
    end else begin
      ref_q <= pif.ref_clk;
      if (ref_rise) begin
        ndiv_q <= ndiv_wrap ? 6'h00 : ndiv_q + 6'h01;
        alive_q <= 1'b1;
      end
      credit_q <= credit_q + feed - {9'h000, tick};
    end
  end

  // Two post-scale counters with own phase and duty
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cnt
      logic [8:0] cnt_q;
      wire [8:0] span = {pif.post[g], 3'h0};
      wire [8:0] ph = {1'b0, pif.phase[g]};
      // Phase in eighths of an oscillator period: 45 degree steps
      wire [8:0] pos = (cnt_q >= ph) ? cnt_q - ph : cnt_q + span - ph;
      always_ff @(posedge clk_i) begin
        if (rst_i || !pif.run) begin
          cnt_q <= 9'h000;
          out_q[g] <= 1'b0;
        end else begin
          if (tick) begin
            cnt_q <= ((cnt_q + 9'h001) >= span) ? 9'h000 : cnt_q + 9'h001;
          end
          out_q[g] <= (pos < {1'b0, pif.duty[g]});
        end
      end
    end
  endgenerate

  assign pif.cnt_out = out_q;
  assign pif.alive = alive_q;
endmodule : gcps_pll
`default_nettype wire

/* verif/gcps_clk_src.sv */
// Reference clock source model standing in for the board oscillators
`timescale 1ns/1ps
`default_nettype none
module gcps_clk_src #(
  parameter int HALF = 32
) (
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [3:0] lvl_i,
  output logic [3:0] pins_o
);
  int cnt_q = 0;
  logic ref_q = 1'b0;
  // Slow square wave, far below clk/2 so the pin synchroniser keeps up
  always_ff @(posedge clk_i) begin
    cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
    if (cnt_q == HALF - 1) ref_q <= ~ref_q;
  end
  // Pins 0/1 feed the first PLL, 2/3 the second
  // Even pin positive, odd pin negative leg
  assign pins_o = run_i ? {~ref_q, ref_q, ~ref_q, ref_q} : lvl_i;
endmodule : gcps_clk_src
`default_nettype wire

/* verif/gcps_top_sva.sv */
// Concurrent checks on the ports of the clock select top
`timescale 1ns/1ps
`default_nettype none
module gcps_top_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] global_line_o,
  input wire logic [1:0] pll_one_external_output_o,
  input wire logic [1:0] pll_one_external_output_oe_n_o,
  input wire logic [1:0] pll_two_external_output_o,
  input wire logic [1:0] pll_two_external_output_oe_n_o,
  input wire logic [1:0] pll_one_user_io_i,
  input wire logic [1:0] pll_one_user_io_oe_n_i,
  input wire logic [1:0] pll_two_user_io_i,
  input wire logic [1:0] pll_two_user_io_oe_n_i
);
  logic run_q;
  wire run_wr = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h09;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_rd_hole;
    s_req ##0 (!wb_we_i && wb_adr_i[7:2] > 6'h0a);
  endsequence
  // Shadow of the run bit; set-only, so a plain flag is enough
  always_ff @(posedge clk_i) begin
    if (rst_i) run_q <= 1'b0;
    else if (run_wr && wb_sel_i[0] && wb_dat_i[0]) run_q <= 1'b1;
  end
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_hole_zero: assert property (s_rd_hole |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_rst_quiet: assert property (disable iff (1'b0) rst_i |=>
    global_line_o == 8'h00 && pll_one_external_output_oe_n_o == 2'h3
    && pll_two_external_output_oe_n_o == 2'h3)
    else $error("outputs active after reset");
  a_pass_one: assert property (!run_q && !$past(rst_i) |->
    {pll_one_external_output_o, pll_one_external_output_oe_n_o}
    == $past({pll_one_user_io_i, pll_one_user_io_oe_n_i}))
    else $error("first user pins not passed");
  a_pass_two: assert property (!run_q && !$past(rst_i) |->
    {pll_two_external_output_o, pll_two_external_output_oe_n_o}
    == $past({pll_two_user_io_i, pll_two_user_io_oe_n_i}))
    else $error("second user pins not passed");
  a_run_shown: assert property (run_q ##0 s_req ##0
    (!wb_we_i && wb_adr_i[7:2] == 6'h0a) |=> wb_dat_o[12])
    else $error("run missing in status");
endmodule : gcps_top_sva
bind gcps_top gcps_top_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .global_line_o(global_line_o),
  .pll_one_external_output_o(pll_one_external_output_o),
  .pll_one_external_output_oe_n_o(pll_one_external_output_oe_n_o),
  .pll_two_external_output_o(pll_two_external_output_o),
  .pll_two_external_output_oe_n_o(pll_two_external_output_oe_n_o),
  .pll_one_user_io_i(pll_one_user_io_i),
  .pll_one_user_io_oe_n_i(pll_one_user_io_oe_n_i),
  .pll_two_user_io_i(pll_two_user_io_i),
  .pll_two_user_io_oe_n_i(pll_two_user_io_oe_n_i));
`default_nettype wire

/* verif/gcps_top_tb.sv */
// Self-checking bench for the global clock line select block
`timescale 1ns/1ps
`default_nettype none
module gcps_top_tb;
  import gcps_pkg::*;
  localparam int LIMIT = 20000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, src_run = 1'b0, px;
  logic [7:0] adr = 8'h00, dpin = 8'h00, lac = 8'h00, gl, pv;
  logic [31:0] wdat = 32'h0, rdat, r, ex;
  logic [3:0] sel = 4'h0, lvl = 4'h0, pins;
  logic [1:0] x1, oe1, x2, oe2;
  logic [1:0] uio1 = 2'h1, uoe1 = 2'h2, uio2 = 2'h2, uoe2 = 2'h1;
  int err_total = 0, n_compared = 0, ticks = 0, e1, e5, ep;
  int pin_of [8] = '{0, 1, 0, 1, 2, 3, 2, 3};

  // Free-running 125 MHz clock
  always #4 clk_i = ~clk_i;

  gcps_clk_src #(.HALF(32)) u_src (.clk_i(clk_i), .run_i(src_run),
    .lvl_i(lvl), .pins_o(pins));

  gcps_top #(.NUM_PLL(2), .NUM_LINES(8)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .ded_clk_pins_i(pins), .dual_purpose_clock_pins_i(dpin),
    .logic_array_clk_i(lac), .global_line_o(gl),
    .pll_one_external_output_o(x1), .pll_one_external_output_oe_n_o(oe1),
    .pll_two_external_output_o(x2), .pll_two_external_output_oe_n_o(oe2),
    .pll_one_user_io_i(uio1), .pll_one_user_io_oe_n_i(uoe1),
    .pll_two_user_io_i(uio2), .pll_two_user_io_oe_n_i(uoe2));

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // Hang guard: a stuck handshake ends the run as a failure
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == LIMIT) begin
      err_total++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One classic cycle; ack and data are taken at the same edge
  // Waits as long as it takes; only the hang guard ends a stuck cycle
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    {we, adr, wdat, sel, cyc, stb} <= {w, a, d, 4'hf, 2'b11};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk_i);
  endtask : wb

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, e, r);
  endtask : rdc

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("div_rst", 8'h00, 32'h0000_0102);
    rdc("cnt1_rst", 8'h18, 32'h0004_0001);
    rdc("hole", 8'h30, 32'h0);
    // Out-of-range fields are dropped while their neighbours land
    wb(1'b1, 8'h00, 32'h0000_0521);
    rdc("m_33", 8'h00, 32'h0000_0502);
    wb(1'b1, 8'h00, 32'h0000_2001);
    rdc("m_1", 8'h00, 32'h0000_2002);
    wb(1'b1, 8'h00, 32'h0000_0020);
    rdc("n_0", 8'h00, 32'h0000_2020);
    wb(1'b1, 8'h14, 32'h0002_0300);
    rdc("post_0", 8'h14, 32'h0002_0301);
    wb(1'b1, 8'h14, 32'h0002_0321);
    rdc("post_33", 8'h14, 32'h0002_0301);
    // Every line from its fixed dedicated pin, one pin at a time
    wb(1'b1, 8'h20, 32'h0049_2492);
    for (int p = 0; p < 4; p++) begin
      lvl <= 4'h1 << p;
      repeat (4) @(posedge clk_i);
      for (int k = 0; k < 8; k++) ex[k] = (pin_of[k] == p);
      chk("pin_lines", {24'h0, ex[7:0]}, {24'h0, gl});
    end
    lvl <= 4'h0;
    dpin <= 8'ha5;
    wb(1'b1, 8'h20, 32'h006d_b6db);
    repeat (4) @(posedge clk_i);
    chk("dual_lines", 32'ha5, {24'h0, gl});
    lac <= 8'h3c;
    wb(1'b1, 8'h20, 32'h0092_4924);
    repeat (2) @(posedge clk_i);
    chk("logic_lines", 32'h3c, {24'h0, gl});
    // PLL setup: first with differential external out, second LVDS in
    wb(1'b1, 8'h00, 32'h0006_0102);
    wb(1'b1, 8'h10, 32'h0001_0102);
    wb(1'b1, 8'h20, 32'h0024_9249);
    chk("pass_one", {28'h0, uio1, uoe1}, {28'h0, x1, oe1});
    wb(1'b1, 8'h24, 32'h0000_0001);
    src_run <= 1'b1;
    repeat (200) @(posedge clk_i);
    e1 = 0;
    e5 = 0;
    ep = 0;
    pv = gl;
    px = x1[0];
    // Each ref edge adds 16 steps, one output period is 8 steps
    repeat (640) begin
      @(posedge clk_i);
      e1 += int'(gl[1] & ~pv[1]);
      e5 += int'(gl[5] & ~pv[5]);
      ep += int'(x1[0] & ~px);
      pv = gl;
      px = x1[0];
    end
    chk("pll1_rate", 32'h1, {31'h0, e1 inside {[18:22]}});
    chk("pll2_rate", 32'h1, {31'h0, e5 inside {[18:22]}});
    chk("ext1_rate", 32'h1, {31'h0, ep inside {[18:22]}});
    chk("ext1_oe", 32'h0, {30'h0, oe1});
    chk("ext1_legs", 32'h1, {31'h0, x1[1] === ~x1[0]});
    chk("pass_two", {28'h0, uio2, uoe2}, {28'h0, x2, oe2});
    wb(1'b0, 8'h28, 32'h0);
    chk("status", 32'h1f00, r & 32'h1f00);
    // Settings stay frozen once running
    wb(1'b1, 8'h20, 32'h0);
    rdc("sel_frozen", 8'h20, 32'h0024_9249);
    wb(1'b1, 8'h00, 32'h0000_0504);
    rdc("div_frozen", 8'h00, 32'h0006_0102);
    close_out();
  end
endmodule : gcps_top_tb
`default_nettype wire
